// ### rtl/mirror_array_link_config_regs.sv
// avalon-mm register bank for mirror array link transmit settings
// assumes one clock, async active-high reset, single-word avalon master
// Notes on behaviour
// RULE1 - ch2 data swing bits 3:0, reset 0x9
// RULE2 - ch2 data post-cursor bits 12:8, reset zero
// RULE3 - ch2 data pre-cursor bits 20:16, reset zero
// RULE4 - ch2 clock register, same layout and resets
// RULE5 - ch3 data and clock registers, same layout
// RULE6 - common-mode code bits 2:0, reset 001
// RULE7 - read-only attached array identifier, 32 bits
// RULE8 - four read-only fuse group registers
// RULE9 - unused bits read zero; read-only ignore writes
`timescale 1ns/1ps
module mirror_array_link_config_regs
   import mirror_link_cfg_pkg::*;
(
   input wire logic i_clk_sys,
   input wire logic i_reset,
   input wire logic [5:0] i_address,
   input wire logic i_read,
   input wire logic i_write,
   input wire logic [3:0] i_byteenable,
   input wire logic [31:0] i_writedata,
   output logic [31:0] o_readdata,
   output logic o_waitrequest,
   output logic [1:0] o_response,
   input wire logic i_info_valid,
   input wire logic [31:0] i_ident,
   input wire logic [31:0] i_fuse [LANES],
   output logic [3:0] o_driver_swing [LANES],
   output logic [4:0] o_post_cursor_emphasis [LANES],
   output logic [4:0] o_pre_cursor_emphasis [LANES],
   output logic [2:0] o_common_mode_code
);
   // ----------------------------------------
   // bus handshake
   // ----------------------------------------
   // one wait state: a request is answered on its second edge, which gives
   // registered read data without a combinational path from address
   typedef enum logic {ST_IDLE, ST_ACK} bus_state_t;
   bus_state_t state_r, state_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   logic [1:0] resp_r, resp_nxt;
   logic req;
   logic wr_fire;
   logic [31:0] lane_rdata [LANES];
   logic [31:0] ident_q;
   logic [31:0] fuse_q [LANES];
   logic [2:0] cm_r, cm_nxt;

   function automatic logic is_mapped(input logic [5:0] a);
      is_mapped = (a <= OFF_FUSE4) && (a[1:0] == 2'h0);
   endfunction : is_mapped

   assign req = i_read || i_write;
   // the write lands on the edge where waitrequest is low
   assign wr_fire = i_write && (state_r == ST_ACK);
   assign o_waitrequest = req && (state_r != ST_ACK);

   // ----------------------------------------
   // lane registers
   // ----------------------------------------
   for (genvar g = 0; g < LANES; g++) begin : g_lane
      lane_tx_ctrl_reg u_lane (
         .i_clk_sys(i_clk_sys),
         .i_reset(i_reset),
         .i_wr(wr_fire && (i_address == 6'(g * 4))), // RULE4 RULE5
         .i_byteenable(i_byteenable),
         .i_wdata(i_writedata),
         .o_driver_swing(o_driver_swing[g]),
         .o_post_cursor_emphasis(o_post_cursor_emphasis[g]),
         .o_pre_cursor_emphasis(o_pre_cursor_emphasis[g]),
         .o_rdata(lane_rdata[g])
      );
   end

   array_info_capture u_info (
      .i_clk_sys(i_clk_sys),
      .i_reset(i_reset),
      .i_info_valid(i_info_valid),
      .i_ident(i_ident),
      .i_fuse(i_fuse),
      .o_ident(ident_q),
      .o_fuse(fuse_q)
   );

   // ----------------------------------------
   // common-mode code
   // ----------------------------------------
   always_comb begin
      cm_nxt = cm_r;
      if (wr_fire && i_address == OFF_COMMON_MODE && i_byteenable[0]) begin
         cm_nxt = i_writedata[CM_MSB:0]; // RULE6
      end
   end

   always_ff @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         cm_r <= CM_RST; // RULE6
      end else begin
         cm_r <= cm_nxt;
      end
   end

   assign o_common_mode_code = cm_r;

   // ----------------------------------------
   // read mux and response
   // ----------------------------------------
   always_comb begin
      state_nxt = state_r;
      rdata_nxt = rdata_r;
      resp_nxt = resp_r;
      case (state_r)
         ST_IDLE: begin
            if (req) begin
               state_nxt = ST_ACK;
               resp_nxt = is_mapped(i_address) ? 2'h0 : 2'h3;
               case (i_address)
                  OFF_CH2_DATA: rdata_nxt = lane_rdata[0];
                  OFF_CH2_CLK: rdata_nxt = lane_rdata[1];
                  OFF_CH3_DATA: rdata_nxt = lane_rdata[2];
                  OFF_CH3_CLK: rdata_nxt = lane_rdata[3];
                  OFF_COMMON_MODE: rdata_nxt = {29'h0000_0000, cm_r}; // RULE9
                  OFF_IDENT: rdata_nxt = ident_q; // RULE7
                  OFF_FUSE1: rdata_nxt = fuse_q[0]; // RULE8
                  OFF_FUSE2: rdata_nxt = fuse_q[1];
                  OFF_FUSE3: rdata_nxt = fuse_q[2];
                  OFF_FUSE4: rdata_nxt = fuse_q[3];
                  default: rdata_nxt = UNMAPPED_READ;
               endcase
            end
         end
         ST_ACK: begin
            state_nxt = ST_IDLE;
         end
         default: begin
            state_nxt = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         state_r <= ST_IDLE;
         rdata_r <= UNMAPPED_READ;
         resp_r <= 2'h0;
      end else begin
         state_r <= state_nxt;
         rdata_r <= rdata_nxt;
         resp_r <= resp_nxt;
      end
   end

   assign o_readdata = rdata_r;
   assign o_response = resp_r;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   sequence s_req_start;
      req && state_r == ST_IDLE;
   endsequence
   sequence s_req_ack;
      !o_waitrequest && state_r == ST_ACK;
   endsequence
   sequence s_cm_write;
      wr_fire && i_address == OFF_COMMON_MODE && i_byteenable[0];
   endsequence

   // the master may rely on exactly one wait state
   a_one_wait_state: assert property (@(posedge i_clk_sys) disable iff (i_reset) // RULE9
      s_req_start |-> o_waitrequest ##1 s_req_ack)
      else $error("request not answered after one wait state");
   a_unmapped_error: assert property (@(posedge i_clk_sys) disable iff (i_reset) // RULE9
      req && state_r == ST_IDLE && !is_mapped(i_address)
      |=> o_response == 2'h3 && o_readdata == UNMAPPED_READ)
      else $error("unmapped access not refused");
   a_mapped_okay: assert property (@(posedge i_clk_sys) disable iff (i_reset) // RULE9
      req && state_r == ST_IDLE && is_mapped(i_address) |=> o_response == 2'h0)
      else $error("mapped access not answered okay");
   a_cm_write_lands: assert property (@(posedge i_clk_sys) disable iff (i_reset) // RULE6
      s_cm_write |=> o_common_mode_code == $past(i_writedata[2:0]))
      else $error("common-mode code not written");
   a_cm_holds: assert property (@(posedge i_clk_sys) disable iff (i_reset) // RULE6
      !(wr_fire && i_address == OFF_COMMON_MODE && i_byteenable[0])
      |=> $stable(o_common_mode_code))
      else $error("common-mode code changed without a write");
   a_cm_read_upper: assert property (@(posedge i_clk_sys) disable iff (i_reset) // RULE9
      state_r == ST_ACK && $past(i_address) == OFF_COMMON_MODE
      |-> o_readdata[31:3] == 29'h0000_0000)
      else $error("common-mode upper bits not zero");
   a_ident_no_write: assert property (@(posedge i_clk_sys) disable iff (i_reset) // RULE7
      wr_fire && i_address == OFF_IDENT && !i_info_valid |=> $stable(ident_q))
      else $error("identifier changed by bus write");
   a_ident_read_back: assert property (@(posedge i_clk_sys) disable iff (i_reset) // RULE7
      req && state_r == ST_IDLE && i_address == OFF_IDENT
      |=> o_readdata == $past(ident_q))
      else $error("identifier read wrong");
   // fuse words only move on a capture from the array side
   a_fuse_no_write: assert property (@(posedge i_clk_sys) disable iff (i_reset) // RULE9
      wr_fire && i_address >= OFF_FUSE1 && i_address <= OFF_FUSE4 && !i_info_valid
      |=> $stable(fuse_q[0]) && $stable(fuse_q[3]))
      else $error("fuse group changed by bus write");
   a_fuse_one_read: assert property (@(posedge i_clk_sys) disable iff (i_reset) // RULE8
      req && state_r == ST_IDLE && i_address == OFF_FUSE1
      |=> o_readdata == $past(fuse_q[0]))
      else $error("fuse group one read wrong");
   a_fuse_four_read: assert property (@(posedge i_clk_sys) disable iff (i_reset) // RULE8
      req && state_r == ST_IDLE && i_address == OFF_FUSE4
      |=> o_readdata == $past(fuse_q[3]))
      else $error("fuse group four read wrong");
   a_lane_reads_zero: assert property (@(posedge i_clk_sys) disable iff (i_reset) // RULE5
      state_r == ST_ACK && $past(i_address) == OFF_CH3_CLK
      |-> o_readdata[31:21] == 11'h000 && o_readdata[7:4] == 4'h0)
      else $error("lane reserved bits not zero");
   a_lane_read_back: assert property (@(posedge i_clk_sys) disable iff (i_reset) // RULE1
      req && state_r == ST_IDLE && i_address == OFF_CH2_DATA
      |=> o_readdata == $past(lane_rdata[0]))
      else $error("ch2 data lane read wrong");
   a_ch2_data_swing: assert property (@(posedge i_clk_sys) disable iff (i_reset) // RULE1
      wr_fire && i_address == OFF_CH2_DATA && i_byteenable[0]
      |=> o_driver_swing[0] == $past(i_writedata[3:0]))
      else $error("ch2 data swing not written");
   a_ch2_clk_swing: assert property (@(posedge i_clk_sys) disable iff (i_reset) // RULE4
      wr_fire && i_address == OFF_CH2_CLK && i_byteenable[0]
      |=> o_driver_swing[1] == $past(i_writedata[3:0]))
      else $error("ch2 clock swing not written");
   a_ch2_clk_post: assert property (@(posedge i_clk_sys) disable iff (i_reset) // RULE4
      wr_fire && i_address == OFF_CH2_CLK && i_byteenable[1]
      |=> o_post_cursor_emphasis[1] == $past(i_writedata[12:8]))
      else $error("ch2 clock post cursor not written");
   a_ch3_data_swing: assert property (@(posedge i_clk_sys) disable iff (i_reset) // RULE5
      wr_fire && i_address == OFF_CH3_DATA && i_byteenable[0]
      |=> o_driver_swing[2] == $past(i_writedata[3:0]))
      else $error("ch3 data swing not written");
   a_ch3_clk_pre: assert property (@(posedge i_clk_sys) disable iff (i_reset) // RULE5
      wr_fire && i_address == OFF_CH3_CLK && i_byteenable[2]
      |=> o_pre_cursor_emphasis[3] == $past(i_writedata[20:16]))
      else $error("ch3 clock pre cursor not written");
endmodule : mirror_array_link_config_regs

// ### include/mirror_link_cfg_pkg.sv
// register offsets, field layouts and reset values for the mirror array link config bank
// assumes a 32-bit avalon-mm slave with word-aligned byte addresses
package mirror_link_cfg_pkg;
   // ----------------------------------------
   // offsets (byte addresses)
   // ----------------------------------------
   localparam logic [5:0] OFF_CH2_DATA = 6'h00;
   localparam logic [5:0] OFF_CH2_CLK = 6'h04;
   localparam logic [5:0] OFF_CH3_DATA = 6'h08;
   localparam logic [5:0] OFF_CH3_CLK = 6'h0c;
   localparam logic [5:0] OFF_COMMON_MODE = 6'h10;
   localparam logic [5:0] OFF_IDENT = 6'h14;
   localparam logic [5:0] OFF_FUSE1 = 6'h18;
   localparam logic [5:0] OFF_FUSE2 = 6'h1c;
   localparam logic [5:0] OFF_FUSE3 = 6'h20;
   localparam logic [5:0] OFF_FUSE4 = 6'h24;
   // ----------------------------------------
   // field positions
   // ----------------------------------------
   localparam int SWING_LSB = 0;
   localparam int SWING_MSB = 3;
   localparam int POST_LSB = 8;
   localparam int POST_MSB = 12;
   localparam int PRE_LSB = 16;
   localparam int PRE_MSB = 20;
   localparam int CM_MSB = 2;
   localparam int LANES = 4;
   // ----------------------------------------
   // reset values
   // ----------------------------------------
   localparam logic [3:0] SWING_RST = 4'h9;
   localparam logic [4:0] POST_RST = 5'h00;
   localparam logic [4:0] PRE_RST = 5'h00;
   localparam logic [2:0] CM_RST = 3'h1;
   localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
   localparam logic [31:0] ROM_RST = 32'h0000_0000;
endpackage : mirror_link_cfg_pkg

// ### rtl/lane_tx_ctrl_reg.sv
// one lane's swing / post / pre cursor register
// assumes write strobe already decoded by the bus slave
`timescale 1ns/1ps
module lane_tx_ctrl_reg
   import mirror_link_cfg_pkg::*;
(
   input wire logic i_clk_sys,
   input wire logic i_reset,
   input wire logic i_wr,
   input wire logic [3:0] i_byteenable,
   input wire logic [31:0] i_wdata,
   output logic [3:0] o_driver_swing,
   output logic [4:0] o_post_cursor_emphasis,
   output logic [4:0] o_pre_cursor_emphasis,
   output logic [31:0] o_rdata
);
   logic [3:0] swing_r, swing_nxt;
   logic [4:0] post_r, post_nxt;
   logic [4:0] pre_r, pre_nxt;

   always_comb begin
      swing_nxt = swing_r;
      post_nxt = post_r;
      pre_nxt = pre_r;
      if (i_wr && i_byteenable[0]) begin
         swing_nxt = i_wdata[SWING_MSB:SWING_LSB]; // RULE1
      end
      if (i_wr && i_byteenable[1]) begin
         post_nxt = i_wdata[POST_MSB:POST_LSB]; // RULE2
      end
      if (i_wr && i_byteenable[2]) begin
         pre_nxt = i_wdata[PRE_MSB:PRE_LSB]; // RULE3
      end
   end

   always_ff @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         swing_r <= SWING_RST; // RULE1
         post_r <= POST_RST; // RULE2
         pre_r <= PRE_RST; // RULE3
      end else begin
         swing_r <= swing_nxt;
         post_r <= post_nxt;
         pre_r <= pre_nxt;
      end
   end

   assign o_driver_swing = swing_r;
   assign o_post_cursor_emphasis = post_r;
   assign o_pre_cursor_emphasis = pre_r;
   // unused bits stay zero on read
   assign o_rdata = {11'h000, pre_r, 3'h0, post_r, 4'h0, swing_r}; // RULE9

   a_swing_holds: assert property (@(posedge i_clk_sys) disable iff (i_reset) // RULE1
      !(i_wr && i_byteenable[0]) |=> swing_r == $past(swing_r))
      else $error("swing changed without a write");
   a_post_loads: assert property (@(posedge i_clk_sys) disable iff (i_reset) // RULE2
      i_wr && i_byteenable[1] |=> post_r == $past(i_wdata[12:8]))
      else $error("post cursor not loaded");
   a_pre_loads: assert property (@(posedge i_clk_sys) disable iff (i_reset) // RULE3
      i_wr && i_byteenable[2] |=> pre_r == $past(i_wdata[20:16]))
      else $error("pre cursor not loaded");
endmodule : lane_tx_ctrl_reg

// ### rtl/array_info_capture.sv
// captures the attached array identifier and fuse groups
// assumes the link side presents i_info_valid once the array has been read
`timescale 1ns/1ps
module array_info_capture
   import mirror_link_cfg_pkg::*;
(
   input wire logic i_clk_sys,
   input wire logic i_reset,
   input wire logic i_info_valid,
   input wire logic [31:0] i_ident,
   input wire logic [31:0] i_fuse [LANES],
   output logic [31:0] o_ident,
   output logic [31:0] o_fuse [LANES]
);
   logic [31:0] ident_r, ident_nxt;
   logic [31:0] fuse_r [LANES];
   logic [31:0] fuse_nxt [LANES];

   // only the array side updates these; bus writes never reach here
   always_comb begin
      ident_nxt = ident_r;
      fuse_nxt = fuse_r;
      if (i_info_valid) begin
         ident_nxt = i_ident; // RULE7
         fuse_nxt = i_fuse; // RULE8
      end
   end

   always_ff @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         ident_r <= ROM_RST;
         for (int k = 0; k < LANES; k++) begin
            fuse_r[k] <= ROM_RST;
         end
      end else begin
         ident_r <= ident_nxt;
         fuse_r <= fuse_nxt;
      end
   end

   assign o_ident = ident_r;
   assign o_fuse = fuse_r;

   a_ident_stable: assert property (@(posedge i_clk_sys) disable iff (i_reset) // RULE7
      !i_info_valid |=> $stable(ident_r))
      else $error("identifier moved without capture");
   a_fuse_capture: assert property (@(posedge i_clk_sys) disable iff (i_reset) // RULE8
      i_info_valid |=> fuse_r[3] == $past(i_fuse[3]))
      else $error("fuse group four not captured");
endmodule : array_info_capture

// ### verif/array_rx_model.sv
// far-side model: serves the attached array identifier and fuse groups
// assumes the bench raises i_load for one cycle, by non-blocking assignment
`timescale 1ns/1ps
module array_rx_model
   import mirror_link_cfg_pkg::*;
(
   input wire logic i_clk_sys,
   input wire logic i_load,
   output logic o_info_valid,
   output logic [31:0] o_ident,
   output logic [31:0] o_fuse [LANES]
);
   // --------------------------------
   // info lines
   // --------------------------------
   // outside the valid cycle the lines flip, so a late capture shows up
   initial begin
      o_info_valid = 1'b0;
      o_ident = '0;
      foreach (o_fuse[g]) o_fuse[g] = '0;
   end
   always @(posedge i_clk_sys) begin
      o_info_valid <= i_load;
      o_ident <= i_load ? $urandom : ~o_ident;
      foreach (o_fuse[g]) o_fuse[g] <= i_load ? $urandom : ~o_fuse[g];
   end
endmodule : array_rx_model

// ### verif/test_mirror_array_link_config_regs.sv
// bench for the link config bank: avalon master, shadow copy, read monitor
// assumes one 100 ns clock and the far-side model for identifier and fuses
`timescale 1ns/1ps
module test_mirror_array_link_config_regs;
   import mirror_link_cfg_pkg::*;
   // --------------------------------
   // signals
   // --------------------------------
   logic i_clk_sys = 1'b0, i_reset = 1'b1, i_read = 1'b0, i_write = 1'b0, load = 1'b0;
   logic [5:0] i_address = '0;
   logic [3:0] i_byteenable = '0;
   logic [31:0] i_writedata = '0, o_readdata, ident;
   logic o_waitrequest, info_valid;
   logic [1:0] o_response;
   logic [31:0] fuse [LANES];
   logic [3:0] o_driver_swing [LANES];
   logic [4:0] o_post_cursor_emphasis [LANES], o_pre_cursor_emphasis [LANES];
   logic [2:0] o_common_mode_code;
   logic [33:0] notes [$];
   logic [31:0] shadow [10];
   int errors = 0, comparisons = 0;
   always #50 i_clk_sys = ~i_clk_sys;
   mirror_array_link_config_regs u_dut (.i_clk_sys(i_clk_sys), .i_reset(i_reset),
      .i_address(i_address), .i_read(i_read), .i_write(i_write),
      .i_byteenable(i_byteenable), .i_writedata(i_writedata), .o_readdata(o_readdata),
      .o_waitrequest(o_waitrequest), .o_response(o_response), .i_info_valid(info_valid),
      .i_ident(ident), .i_fuse(fuse), .o_driver_swing(o_driver_swing),
      .o_post_cursor_emphasis(o_post_cursor_emphasis),
      .o_pre_cursor_emphasis(o_pre_cursor_emphasis), .o_common_mode_code(o_common_mode_code));
   array_rx_model u_model (.i_clk_sys(i_clk_sys), .i_load(load), .o_info_valid(info_valid),
      .o_ident(ident), .o_fuse(fuse));
   // --------------------------------
   // checks
   // --------------------------------
   task compare(input logic [33:0] got, input logic [33:0] exp);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : compare
   task check_read;
      compare({o_response, o_readdata}, notes.pop_front());
   endtask : check_read
   task check_field(input int l);
      compare({o_driver_swing[l], o_post_cursor_emphasis[l], o_pre_cursor_emphasis[l],
         o_common_mode_code}, {shadow[l][3:0], shadow[l][12:8], shadow[l][20:16], shadow[4][2:0]});
   endtask : check_field
   // answers are taken on the rising edge where waitrequest is seen low
   always @(posedge i_clk_sys) begin
      if (i_read === 1'b1 && o_waitrequest === 1'b0) check_read();
      if (info_valid === 1'b1) begin
         shadow[5] = ident;
         foreach (fuse[g]) shadow[6 + g] = fuse[g];
      end
   end
   // --------------------------------
   // master
   // --------------------------------
   task bus(input logic wr, input logic [5:0] a, input logic [31:0] d, input logic [3:0] be);
      int n;
      n = 0;
      i_read <= !wr;
      i_write <= wr;
      i_address <= a;
      i_writedata <= d;
      i_byteenable <= be;
      if (!wr) notes.push_back((a < 6'h28 && a[1:0] == 2'h0) ? {2'b00, shadow[a[5:2]]} : {2'b11, 32'h0});
      if (wr && a < 6'h14 && a[1:0] == 2'h0) begin
         for (int b = 0; b < 4; b++) if (be[b]) shadow[a[5:2]][8*b +: 8] = d[8*b +: 8];
         shadow[a[5:2]] &= (a < 6'h10) ? 32'h001f_1f0f : 32'h0000_0007;
      end
      do begin
         @(posedge i_clk_sys);
         n++;
      end while (o_waitrequest !== 1'b0 && n < 50);
      if (n >= 50) begin
         errors++;
         give_verdict();
      end
      i_read <= 1'b0;
      i_write <= 1'b0;
      @(posedge i_clk_sys);
   endtask : bus
   task do_reset;
      i_reset <= 1'b1;
      repeat (2) @(posedge i_clk_sys);
      i_reset <= 1'b0;
      foreach (shadow[i]) shadow[i] = (i < 4) ? 32'h9 : (i == 4) ? 32'h1 : 32'h0;
      @(posedge i_clk_sys);
   endtask : do_reset
   task read_all;
      for (int a = 0; a < 12; a++) bus(1'b0, 6'(a * 4), 32'h0, 4'h0);
      @(negedge i_clk_sys);
      for (int l = 0; l < LANES; l++) check_field(l);
      @(posedge i_clk_sys);
   endtask : read_all
   task give_verdict;
      $display("errors %0d comparisons %0d", errors, comparisons);
      if (errors == 0 && comparisons > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : give_verdict
   // --------------------------------
   // tests
   // --------------------------------
   initial begin
      logic [5:0] a;
      void'($urandom(32'hb701));
      do_reset();
      read_all();
      for (int k = 0; k < 40; k++) begin
         a = 6'(($urandom % 11) * 4);
         bus(1'b1, a, $urandom, 4'($urandom));
         bus(1'b0, a, 32'h0, 4'h0);
         @(negedge i_clk_sys);
         check_field(k % 4);
         @(posedge i_clk_sys);
      end
      // a misaligned word is refused and must leave the common-mode code alone
      bus(1'b1, 6'h11, 32'hffff_ffff, 4'hf);
      bus(1'b0, 6'h11, 32'h0, 4'h0);
      load <= 1'b1;
      @(posedge i_clk_sys);
      load <= 1'b0;
      repeat (3) @(posedge i_clk_sys);
      for (int a2 = 5; a2 < 10; a2++) bus(1'b1, 6'(a2 * 4), $urandom, 4'hf);
      read_all();
      do_reset();
      read_all();
      give_verdict();
   end
   initial begin
      #(100 * 20000);
      errors++;
      give_verdict();
   end
endmodule : test_mirror_array_link_config_regs
